/* File: bench/lfb_node_model.sv */
// far-side node: hands classified bytes to the block, models the bus wire
// assumes push is called right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module lfb_node_model (
	input wire logic              i_clk,       // clock
	input wire logic              i_ready,     // block takes byte
	input wire logic              i_tx_active, // block drives
	input wire logic              i_tx_bit,    // driven level
	input wire logic              i_jam,       // hold bus dominant
	output logic                  o_valid,     // byte valid
	output lfb_pkg::lfb_byte_type o_byte,      // byte
	output logic                  o_lin        // bus level
);
	// wired-and with pull-up: a released bus reads recessive high
	assign o_lin = !i_jam && (!i_tx_active || i_tx_bit);
	initial begin
		o_valid = 1'b0;
		o_byte  = '0;
	end
	// held until taken; released data is scrambled so nothing stale passes
	task automatic push(input logic [1:0] k, input logic [7:0] d, input int gap);
		o_valid <= 1'b1;
		o_byte  <= {k, d};
		do @(negedge i_clk); while (!i_ready);
		@(posedge i_clk);
		if (gap > 0) begin
			o_valid <= 1'b0;
			o_byte  <= ~{k, d};
			repeat (gap) @(posedge i_clk);
		end
	endtask
endmodule
`default_nettype wire

/* File: bench/lfb_regs_properties.sv */
// port checker for the lin fault block
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "lfb_map.svh"
module lfb_regs_checker (
	input wire logic                  i_clk,              // clock
	input wire logic                  i_reset,            // reset
	input wire logic                  i_hsel,             // select
	input wire logic [31:0]           i_haddr,            // address
	input wire logic [1:0]            i_htrans,           // transfer
	input wire logic                  i_hwrite,           // write
	input wire logic [31:0]           i_hwdata,           // wdata
	input wire logic                  i_hready,           // ready in
	input wire logic                  o_hreadyout,        // ready out
	input wire logic [31:0]           o_hrdata,           // rdata
	input wire logic                  i_rx_valid,         // byte valid
	input wire lfb_pkg::lfb_byte_type i_rx_byte,          // byte
	input wire logic                  o_rx_ready,         // fifo room
	input wire logic                  i_lin_rx,           // bus level
	input wire logic                  i_tx_active,        // driving
	input wire logic                  i_tx_bit,           // driven level
	input wire logic                  i_bit_sample,       // strobe
	input wire logic [4:0]            o_baud_multiplier,  // multiplier
	input wire logic [3:0]            o_data_length,      // length
	input wire logic                  o_slave_mode,       // slave
	input wire logic                  o_fault_error,      // error
	input wire logic                  o_fault_irq_pending // pending
);
	logic take;
	logic ctl_wr_ff;
	assign take = i_hsel && i_htrans[1] && i_hready;
	// a control write in its data phase; the clear lands at its end
	always_ff @(posedge i_clk) begin
		ctl_wr_ff <= !i_reset && take && i_hwrite && i_haddr == 32'({`LFB_IDX_CTRL, 2'b00});
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	property p_wr_nowait; take && i_hwrite |=> o_hreadyout; endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write waited");
	property p_rd_wait; take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read timing wrong");
	property p_upper_zero; o_hrdata[31:8] == 24'h0; endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
	property p_len_max; o_data_length <= 4'h8; endproperty
	a_len_max: assert property (p_len_max) else $error("length above eight");
	property p_mul_slave; o_slave_mode |-> o_baud_multiplier == 5'h00; endproperty
	a_mul_slave: assert property (p_mul_slave) else $error("multiplier in slave");
	property p_rst_vals; $fell(i_reset) |-> o_baud_multiplier == 5'h1f && !o_fault_error; endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset value wrong");
	property p_sync; i_rx_valid && o_rx_ready && o_slave_mode && i_rx_byte.kind ==
		lfb_pkg::LFB_K_SYNC && i_rx_byte.data != 8'h55 |-> ##[2:12] o_fault_error; endproperty
	a_sync: assert property (p_sync) else $error("sync fault missed");
	property p_bitrb; i_bit_sample && i_tx_active && i_tx_bit != i_lin_rx && $stable(i_lin_rx)
		&& i_lin_rx == $past(i_lin_rx, 2) |-> ##[1:4] o_fault_error; endproperty
	a_bitrb: assert property (p_bitrb) else $error("readback fault missed");
	property p_clear; ctl_wr_ff && o_hreadyout && i_hwdata[2] |=> !o_fault_error; endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");
	property p_pending; $rose(o_fault_error) |-> o_fault_irq_pending; endproperty
	a_pending: assert property (p_pending) else $error("no pending request");
	c_read: cover property (take && !i_hwrite ##1 !o_hreadyout);
	c_fill: cover property (i_rx_valid && !o_rx_ready);
	c_fault: cover property ($rose(o_fault_error));
endmodule
`default_nettype wire

/* File: bench/lin_fault_size_baud_regs_tb.sv */
// self-checking bench for the lin fault block
// assumes the node model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "lfb_map.svh"
module lin_fault_size_baud_regs_tb;
	localparam int FRAME_CYC = 64;
	localparam int RESP_CYC  = 32;
	logic                  clk, rst, hsel, hwrite, hrdy, rxv, rxr, lin, txa, txb, smp, jam;
	logic                  enh_o, slv, err, pend;
	logic [1:0]            htrans, pre;
	logic [3:0]            len;
	logic [4:0]            mul;
	logic [8:0]            div;
	logic [31:0]           haddr, hwdata, hrdata, r, v, e;
	lfb_pkg::lfb_byte_type rxb;
	int                    failures, checked, refused, enh;
	int                    lens[4] = '{2, 2, 4, 8};
	lfb_regs #(.FRAME_CYC(FRAME_CYC), .RESP_CYC(RESP_CYC), .FIFO_DEPTH(4)) u_dut (
		.i_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy),
		.o_hreadyout(hrdy), .o_hresp(), .o_hrdata(hrdata), .i_rx_valid(rxv),
		.i_rx_byte(rxb), .o_rx_ready(rxr), .i_lin_rx(lin), .i_tx_active(txa),
		.i_tx_bit(txb), .i_bit_sample(smp), .o_baud_divider(div), .o_baud_prescaler(pre),
		.o_baud_multiplier(mul), .o_data_length(len), .o_enhanced_checksum(enh_o),
		.o_slave_mode(slv), .o_fault_error(err), .o_fault_irq_pending(pend));
	lfb_node_model u_node (.i_clk(clk), .i_ready(rxr), .i_tx_active(txa), .i_tx_bit(txb),
		.i_jam(jam), .o_valid(rxv), .o_byte(rxb), .o_lin(lin));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// the fifo pushing back on a waiting byte
	always @(negedge clk) if (rxv && !rxr) refused++;
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// single transfer; no latency assumed, the hready wait is open
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {22'h0, idx, 2'b00};
		do @(negedge clk); while (!hrdy);
		@(posedge clk);
		htrans <= 2'b00;
		hwdata <= d;
		do @(negedge clk); while (!hrdy);
		r = hrdata;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] x);
		bus(1'b0, idx, 32'h0);
		chk(r, x);
	endtask
	function automatic logic [7:0] pidf(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction
	// let the queue drain, compare flags, then clear flags and pending
	task automatic settle(input logic [4:0] ef);
		repeat (12) @(posedge clk);
		rd(`LFB_IDX_FAULT, {27'h0, ef});
		chk({err, pend}, {2{ef != 5'h00}});
		wr(`LFB_IDX_CTRL, 32'h0c);
		rd(`LFB_IDX_FAULT, 32'h0);
		bus(1'b0, `LFB_IDX_CTRL, 32'h0);
		chk(r & 32'h0c, 32'h0);
	endtask
	// one slave frame with the checksum reckoned here
	task automatic frame(input logic [7:0] sy, input bit pok, input logic [7:0] ack,
		input int n, input int dl, input bit cok, input logic [4:0] ef);
		logic [7:0] p;
		logic [7:0] d;
		int         s;
		p = pidf(6'($urandom)) ^ (pok ? 8'h00 : 8'h40);
		s = enh ? p : 0;
		u_node.push(2'h0, sy, 1);
		u_node.push(2'h1, p, 1);
		if (ack != 8'h00) wr(`LFB_IDX_CTRL, {24'h0, ack});
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			s = s + d;
			if (s > 255) s = s - 255;
			u_node.push(2'h2, d, (i == n - 1) ? 1 : 0);
		end
		repeat (dl) @(posedge clk);
		u_node.push(2'h3, ~s[7:0] ^ (cok ? 8'h00 : 8'h01), 1);
		settle(ef);
	endtask
	task automatic print_verdict;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// cut a hang short; the tests need far fewer cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict;
	end
	initial begin
		{failures, checked, refused, enh} = '0;
		{rst, hsel, haddr, htrans, hwrite, hwdata} = '1;
		{txa, txb, smp, jam} = 4'b0100;
		r = $urandom(32'h598d);
		repeat (20) @(posedge clk);
		{rst, hsel, htrans} <= '0;
		@(posedge clk);
		rd(`LFB_IDX_FAULT, 32'h00);
		rd(`LFB_IDX_DIVL, 32'hff);
		rd(`LFB_IDX_SCALE, 32'hff);
		rd(`LFB_IDX_ID, 32'h00);
		rd(8'h10, 32'h00);
		wr(`LFB_IDX_FAULT, 32'hff);
		rd(`LFB_IDX_FAULT, 32'h00);
		for (int c = 0; c < 16; c++) begin
			v = $urandom & 32'hf0 | c;
			wr(`LFB_IDX_SIZE, v);
			rd(`LFB_IDX_SIZE, v & 32'h8f);
			chk(len, c <= 8 ? c : c == 15 ? 2 : 0);
			chk(enh_o, v[7]);
		end
		for (int j = 0; j < 4; j++) begin
			v = 32'hc0 | j << 4 | $urandom & 32'hf;
			wr(`LFB_IDX_ID, v);
			rd(`LFB_IDX_ID, v & 32'h3f);
			chk(len, lens[j]);
		end
		for (int i = 0; i < 4; i++) begin
			v = 200 + $urandom % 312;
			e = $urandom & 32'hfe | v[8];
			wr(`LFB_IDX_DIVL, v & 32'hff);
			wr(`LFB_IDX_SCALE, e);
			wr(`LFB_IDX_MODE, i & 1);
			rd(`LFB_IDX_SCALE, e);
			chk(div, v);
			chk(pre, e[7:6]);
			chk(mul, i[0] ? 0 : e[5:1]);
			chk(slv, i & 1);
		end
		$display("test registers done");
		wr(`LFB_IDX_MODE, 1);
		for (int k = 0; k < 2; k++) begin
			enh = k;
			wr(`LFB_IDX_SIZE, k << 7 | 8);
			frame(8'h55, 1, 8'h10, 1 + $urandom % 8, 0, 1, 5'h00);
		end
		frame(8'h55, 1, 8'h10, 8, 0, 1, 5'h00);
		chk(refused != 0, 1);
		frame(8'h54, 1, 8'h10, 1, 0, 1, 5'h10);
		frame(8'h55, 0, 8'h10, 1, 0, 1, 5'h08);
		frame(8'h55, 1, 8'h00, 1, 0, 1, 5'h04);
		frame(8'h55, 1, 8'h80, 1, 0, 1, 5'h00);
		frame(8'h55, 1, 8'h10, 2, 0, 0, 5'h02);
		frame(8'h55, 1, 8'h10, 1, FRAME_CYC + 8, 1, 5'h04);
		$display("test frames done");
		for (int m = 1; m >= 0; m--) begin
			wr(`LFB_IDX_MODE, m);
			u_node.push(2'h0, 8'h55, 1);
			u_node.push(2'h1, pidf(6'h11), 1);
			repeat (RESP_CYC) @(posedge clk);
			settle(5'h04);
		end
		$display("test timeouts done");
		txa <= 1'b1;
		for (int b = 0; b < 2; b++) begin
			jam <= b[0];
			repeat (4) @(posedge clk);
			smp <= 1'b1;
			@(posedge clk);
			smp <= 1'b0;
			settle(b ? 5'h01 : 5'h00);
		end
		$display("test readback done");
		print_verdict;
	end
endmodule
bind lfb_regs lfb_regs_checker u_chk (.i_clk, .i_reset, .i_hsel, .i_haddr, .i_htrans,
	.i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hrdata, .i_rx_valid, .i_rx_byte,
	.o_rx_ready, .i_lin_rx, .i_tx_active, .i_tx_bit, .i_bit_sample, .o_baud_multiplier,
	.o_data_length, .o_slave_mode, .o_fault_error, .o_fault_irq_pending);
`default_nettype wire

/* File: common/lfb_map.svh */
// register map, field positions, reset values and timing for the lin fault block
// assumes a 40 MHz clock; indices are multiplied by four for bus byte addresses
`ifndef LFB_MAP_SVH
`define LFB_MAP_SVH

// register indices (byte address = index * 4)
`define LFB_IDX_CTRL   8'h08
`define LFB_IDX_STAT   8'h09
`define LFB_IDX_FAULT  8'h0a
`define LFB_IDX_SIZE   8'h0b
`define LFB_IDX_DIVL   8'h0c
`define LFB_IDX_SCALE  8'h0d
`define LFB_IDX_ID     8'h0e
`define LFB_IDX_MODE   8'h0f

// control register bits
`define LFB_CTRL_STOP   7
`define LFB_CTRL_DATA_ACKNOWLEDGE  4
`define LFB_CTRL_RSTINT 3
`define LFB_CTRL_CLEAR_FAULT_FLAGS 2
// status register bits
`define LFB_STAT_INT    3
`define LFB_STAT_ERR    2
// fault register bits
`define LFB_F_SYNC  4
`define LFB_F_PAR   3
`define LFB_F_TIMEOUT_FAULT  2
`define LFB_F_CHK   1
`define LFB_F_BIT   0
`define LFB_F_W     5
// size register fields
`define LFB_SIZE_ENH   7
`define LFB_LEN_MAX    4'h8
`define LFB_LEN_FROMID 4'hf
// scale register fields
`define LFB_PRE_HI  7
`define LFB_PRE_LO  6
`define LFB_MUL_HI  5
`define LFB_MUL_LO  1
`define LFB_DIVIDER_TOP_BIT    0
// mode register bit (slave when set)
`define LFB_MODE_SLAVE 0

// reset values
`define LFB_RST_FAULT 5'h00
`define LFB_RST_SIZE  8'h00
`define LFB_RST_DIVL  8'hff
`define LFB_RST_SCALE 8'hff
`define LFB_RST_ID    6'h00

// frame constants and timing
`define LFB_SYNC_PATTERN  8'h55
`define LFB_CLK_PERIOD_NS 25
`define LFB_FRAME_MAX_US  10000
`define LFB_RESP_MAX_US   5000
`define LFB_FRAME_CYC (`LFB_FRAME_MAX_US * 1000 / `LFB_CLK_PERIOD_NS)
`define LFB_RESP_CYC  (`LFB_RESP_MAX_US * 1000 / `LFB_CLK_PERIOD_NS)

`endif

/* File: common/lfb_pkg.sv */
// types shared by the lin fault block and its bench
// assumes lfb_map.svh supplies all numeric constants
package lfb_pkg;

	// kind of each byte the frame engine hands over
	typedef enum logic [1:0] {
		LFB_K_SYNC = 2'h0,
		LFB_K_PID  = 2'h1,
		LFB_K_DATA = 2'h2,
		LFB_K_CSUM = 2'h3
	} lfb_kind_type;

	typedef struct packed {
		lfb_kind_type kind;
		logic [7:0]   data;
	} lfb_byte_type;

	// bus data-phase state
	typedef enum logic [3:0] {
		LFB_AH_IDLE = 4'b0001,
		LFB_AH_WR   = 4'b0010,
		LFB_AH_RDW  = 4'b0100,
		LFB_AH_RDD  = 4'b1000
	} lfb_ahb_type;

endpackage

/* File: verilog/lfb_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module lfb_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 4
) (
	input  wire logic         i_clk,    // system clock
	input  wire logic         i_reset,  // sync reset, high
	input  wire logic         i_valid,  // write side valid
	input  wire logic [W-1:0] i_data,   // write data
	output logic              o_ready,  // not full
	output logic              o_valid,  // not empty
	output logic      [W-1:0] o_data,   // head word
	input  wire logic         i_ready   // read side takes head
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("lfb_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr_ff;
	logic [AW:0]  rd_ptr_ff;
	logic         push;
	logic         pop;

	// extra pointer bit tells full from empty
	assign o_ready = (wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}};
	assign o_valid = wr_ptr_ff != rd_ptr_ff;
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;
	assign o_data  = mem[rd_ptr_ff[AW-1:0]];

	// storage has no reset; only pointers matter
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_ff[AW-1:0]] <= i_data;
		end
	end

	// pointers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
			rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
		end
	end

endmodule

`default_nettype wire

/* File: verilog/lfb_regs.sv */
// lin fault flags, frame size, baud setting and identifier registers
// assumes an ahb-lite master, a frame engine feeding classified bytes,
// and the raw lin receive pin from the transceiver
`timescale 1ns/1ps
`default_nettype none
`include "lfb_map.svh"

module lfb_regs #(
	parameter int FRAME_CYC = `LFB_FRAME_CYC,
	parameter int RESP_CYC  = `LFB_RESP_CYC,
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic        i_clk,          // 40 MHz system clock
	input  wire logic        i_reset,        // sync reset, high
	input  wire logic        i_hsel,         // ahb slave select
	input  wire logic [31:0] i_haddr,        // ahb address
	input  wire logic [1:0]  i_htrans,       // ahb transfer type
	input  wire logic        i_hwrite,       // ahb write
	input  wire logic [2:0]  i_hsize,        // ahb size
	input  wire logic [31:0] i_hwdata,       // ahb write data
	input  wire logic        i_hready,       // ahb bus ready
	output logic             o_hreadyout,    // ahb slave ready
	output logic             o_hresp,        // ahb response, always okay
	output logic      [31:0] o_hrdata,       // ahb read data
	input  wire logic        i_rx_valid,     // frame engine byte valid
	input  wire lfb_pkg::lfb_byte_type i_rx_byte, // classified byte
	output logic             o_rx_ready,     // byte fifo has room
	input  wire logic        i_lin_rx,       // raw lin bus level
	input  wire logic        i_tx_active,    // block is driving a bit
	input  wire logic        i_tx_bit,       // level being driven
	input  wire logic        i_bit_sample,   // bit sample strobe
	output logic      [8:0]  o_baud_divider, // nine-bit divider
	output logic      [1:0]  o_baud_prescaler, // prescaler
	output logic      [4:0]  o_baud_multiplier, // multiplier, 0 in slave
	output logic      [3:0]  o_data_length,  // data bytes in frame
	output logic             o_enhanced_checksum, // checksum type
	output logic             o_slave_mode,   // slave mode select
	output logic             o_fault_error,  // composite error flag
	output logic             o_fault_irq_pending // pending request
);
	localparam int FCW = $clog2(FRAME_CYC + 1);
	localparam int RCW = $clog2(RESP_CYC + 1);
	localparam int BW  = $bits(lfb_pkg::lfb_byte_type);

	generate
		if (FRAME_CYC < 2 || RESP_CYC < 2) begin : g_bad_time
			$error("lfb_regs timeouts must be at least 2 cycles");
		end
	endgenerate

	// fold the carry back in, as the lin checksum does
	function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	// data length from the size code and identifier
	function automatic logic [3:0] decode_len(input logic [3:0] code, input logic [5:0] id);
		logic [3:0] n;
		n = 4'h0;
		if (code <= `LFB_LEN_MAX) begin
			n = code;
		end else if (code == `LFB_LEN_FROMID) begin
			unique case (id[5:4])
				2'b10:   n = 4'h4;
				2'b11:   n = 4'h8;
				default: n = 4'h2;
			endcase
		end
		return n;
	endfunction

	// identifier parity check bits
	function automatic logic parity_ok(input logic [7:0] pid);
		logic p0;
		logic p1;
		p0 = pid[0] ^ pid[1] ^ pid[2] ^ pid[4];
		p1 = ~(pid[1] ^ pid[3] ^ pid[4] ^ pid[5]);
		return (pid[6] == p0) && (pid[7] == p1);
	endfunction

	// bus side state
	lfb_pkg::lfb_ahb_type ah_state_ff;
	lfb_pkg::lfb_ahb_type nxt_ah_state;
	logic [7:0]  addr_idx_ff;
	logic        addr_ok_ff;
	logic [31:0] rdata_ff;
	logic [31:0] rd_mux;
	logic        accept;
	logic        wr_en;

	// register state
	logic [`LFB_F_W-1:0] fault_ff;
	logic        err_ff;
	logic        int_ff;
	logic        enh_ff;
	logic [3:0]  len_code_ff;
	logic [7:0]  divl_ff;
	logic [7:0]  scale_ff;
	logic [5:0]  id_ff;
	logic        slave_ff;
	logic        data_acknowledge_ff;
	logic        stop_ff;
	logic        wr_ctrl;
	logic        clr_err;
	logic        clr_int;

	// frame checker state
	logic        in_frame_ff;
	logic        resp_wait_ff;
	logic        first_data_ff;
	logic        hold_ff;
	logic [7:0]  sum_ff;
	logic [FCW-1:0] frame_cnt_ff;
	logic [RCW-1:0] resp_cnt_ff;
	logic        q_valid;
	logic        q_take;
	logic [BW-1:0] q_bits;
	lfb_pkg::lfb_byte_type q_byte;
	logic        is_sync;
	logic        is_pid;
	logic        is_data;
	logic        is_csum;

	// readback path
	logic        rx_meta_ff;
	logic        rx_sync_ff;
	logic [1:0]  tx_bit_pipe_ff;
	logic [1:0]  tx_act_pipe_ff;
	logic [1:0]  smp_pipe_ff;

	logic [`LFB_F_W-1:0] ev;

	// ahb-lite: writes complete with zero wait, reads take one wait cycle
	// so that a read right after a write sees the new value
	assign accept = i_hsel & i_htrans[1] & i_hready;
	assign wr_en  = (ah_state_ff == lfb_pkg::LFB_AH_WR) & addr_ok_ff;
	assign o_hreadyout = (ah_state_ff != lfb_pkg::LFB_AH_RDW);
	assign o_hresp  = 1'b0;
	assign o_hrdata = rdata_ff;

	always_comb begin
		if (accept) begin
			nxt_ah_state = i_hwrite ? lfb_pkg::LFB_AH_WR : lfb_pkg::LFB_AH_RDW;
		end else if (ah_state_ff == lfb_pkg::LFB_AH_RDW) begin
			nxt_ah_state = lfb_pkg::LFB_AH_RDD;
		end else begin
			nxt_ah_state = lfb_pkg::LFB_AH_IDLE;
		end
	end

	// address phase capture; only aligned word accesses in range decode
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ah_state_ff <= lfb_pkg::LFB_AH_IDLE;
			addr_idx_ff <= 8'h00;
			addr_ok_ff  <= 1'b0;
		end else begin
			ah_state_ff <= nxt_ah_state;
			if (accept) begin
				addr_idx_ff <= i_haddr[9:2];
				addr_ok_ff  <= (i_haddr[31:10] == 22'h000000) & (i_haddr[1:0] == 2'h0)
				               & (i_hsize == 3'h2);
			end
		end
	end

	// read mux; unused bits and unmapped addresses give zero
	always_comb begin
		rd_mux = 32'h00000000;
		if (addr_ok_ff) begin
			unique case (addr_idx_ff)
				`LFB_IDX_CTRL:  rd_mux[`LFB_CTRL_DATA_ACKNOWLEDGE] = data_acknowledge_ff;
				`LFB_IDX_STAT: begin
					rd_mux[`LFB_STAT_ERR] = err_ff;
					rd_mux[`LFB_STAT_INT] = int_ff;
				end
				`LFB_IDX_FAULT: rd_mux[`LFB_F_W-1:0] = fault_ff;
				`LFB_IDX_SIZE: begin
					rd_mux[`LFB_SIZE_ENH] = enh_ff;
					rd_mux[3:0] = len_code_ff;
				end
				`LFB_IDX_DIVL:  rd_mux[7:0] = divl_ff;
				`LFB_IDX_SCALE: rd_mux[7:0] = scale_ff;
				`LFB_IDX_ID:    rd_mux[5:0] = id_ff;
				`LFB_IDX_MODE:  rd_mux[`LFB_MODE_SLAVE] = slave_ff;
				default:        rd_mux = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rdata_ff <= 32'h00000000;
		end else if (ah_state_ff == lfb_pkg::LFB_AH_RDW) begin
			rdata_ff <= rd_mux;
		end
	end

	// command pulses from a control write; these bits never store
	assign wr_ctrl = wr_en & (addr_idx_ff == `LFB_IDX_CTRL);
	assign clr_err = wr_ctrl & i_hwdata[`LFB_CTRL_CLEAR_FAULT_FLAGS];
	assign clr_int = wr_ctrl & i_hwdata[`LFB_CTRL_RSTINT];

	// configuration registers; only documented bits are stored
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			enh_ff      <= 1'(`LFB_RST_SIZE >> `LFB_SIZE_ENH);
			len_code_ff <= 4'(`LFB_RST_SIZE);
			divl_ff     <= `LFB_RST_DIVL;
			scale_ff    <= `LFB_RST_SCALE;
			slave_ff    <= 1'b0;
		end else if (wr_en) begin
			unique case (addr_idx_ff)
				`LFB_IDX_SIZE: begin
					enh_ff      <= i_hwdata[`LFB_SIZE_ENH];
					len_code_ff <= i_hwdata[3:0];
				end
				`LFB_IDX_DIVL:  divl_ff  <= i_hwdata[7:0];
				`LFB_IDX_SCALE: scale_ff <= i_hwdata[7:0];
				`LFB_IDX_MODE:  slave_ff <= i_hwdata[`LFB_MODE_SLAVE];
				default:        slave_ff <= slave_ff;
			endcase
		end
	end

	// identifier: a slave takes it off the bus, hardware wins a collision
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			id_ff <= `LFB_RST_ID;
		end else if (q_take & is_pid & slave_ff) begin
			id_ff <= q_byte.data[5:0];
		end else if (wr_en & (addr_idx_ff == `LFB_IDX_ID)) begin
			id_ff <= i_hwdata[5:0];
		end
	end

	// baud, frame size, checksum and mode outputs
	assign o_baud_divider    = {scale_ff[`LFB_DIVIDER_TOP_BIT], divl_ff};
	assign o_baud_prescaler  = scale_ff[`LFB_PRE_HI:`LFB_PRE_LO];
	assign o_baud_multiplier = slave_ff ? 5'h00 : scale_ff[`LFB_MUL_HI:`LFB_MUL_LO];
	assign o_data_length     = decode_len(len_code_ff, id_ff);
	assign o_enhanced_checksum = enh_ff;
	assign o_slave_mode      = slave_ff;

	// incoming bytes queue here; the checker drains one every other
	// cycle, so a burst from the frame engine can really back up
	lfb_fifo #(
		.W     (BW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_valid (i_rx_valid),
		.i_data  (i_rx_byte),
		.o_ready (o_rx_ready),
		.o_valid (q_valid),
		.o_data  (q_bits),
		.i_ready (~hold_ff)
	);

	assign q_byte  = lfb_pkg::lfb_byte_type'(q_bits);
	assign q_take  = q_valid & ~hold_ff;
	assign is_sync = q_byte.kind == lfb_pkg::LFB_K_SYNC;
	// after a stop request everything up to the next break is skipped
	assign is_pid  = (q_byte.kind == lfb_pkg::LFB_K_PID) & ~stop_ff;
	assign is_data = (q_byte.kind == lfb_pkg::LFB_K_DATA) & ~stop_ff;
	assign is_csum = (q_byte.kind == lfb_pkg::LFB_K_CSUM) & ~stop_ff;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			hold_ff <= 1'b0;
		end else begin
			hold_ff <= q_take;
		end
	end

	// frame tracking and running checksum
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			in_frame_ff   <= 1'b0;
			resp_wait_ff  <= 1'b0;
			first_data_ff <= 1'b0;
			sum_ff        <= 8'h00;
		end else if (q_take) begin
			if (is_sync) begin
				in_frame_ff  <= 1'b1;
				resp_wait_ff <= 1'b0;
			end else if (is_pid) begin
				resp_wait_ff  <= 1'b1;
				first_data_ff <= 1'b1;
				sum_ff <= enh_ff ? q_byte.data : 8'h00;
			end else if (is_data) begin
				resp_wait_ff  <= 1'b0;
				first_data_ff <= 1'b0;
				sum_ff <= add_carry(sum_ff, q_byte.data);
			end else if (is_csum) begin
				in_frame_ff   <= 1'b0;
				resp_wait_ff  <= 1'b0;
				first_data_ff <= 1'b0;
			end
		end else begin
			// a stopped frame is abandoned, so its timers must not run on
			if (ev[`LFB_F_TIMEOUT_FAULT] | stop_ff) begin
				in_frame_ff  <= 1'b0;
				resp_wait_ff <= 1'b0;
			end
		end
	end

	// frame and response timers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			frame_cnt_ff <= '0;
			resp_cnt_ff  <= '0;
		end else begin
			if (q_take & is_sync) begin
				frame_cnt_ff <= '0;
			end else if (in_frame_ff) begin
				frame_cnt_ff <= frame_cnt_ff + FCW'(1);
			end
			if (q_take & is_pid) begin
				resp_cnt_ff <= '0;
			end else if (resp_wait_ff) begin
				resp_cnt_ff <= resp_cnt_ff + RCW'(1);
			end
		end
	end

	// acknowledge and stop; acknowledge clears on the checksum or sync byte, stop on the next sync byte
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			data_acknowledge_ff <= 1'b0;
			stop_ff  <= 1'b0;
		end else begin
			if (wr_ctrl & i_hwdata[`LFB_CTRL_DATA_ACKNOWLEDGE]) begin
				data_acknowledge_ff <= 1'b1;
			end else if (q_take & (is_sync | is_csum)) begin
				data_acknowledge_ff <= 1'b0;
			end
			if (wr_ctrl & i_hwdata[`LFB_CTRL_STOP]) begin
				stop_ff <= 1'b1;
			end else if (q_take & is_sync) begin
				stop_ff <= 1'b0;
			end
		end
	end

	// bus pin through two flops; tx level delayed to match
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rx_meta_ff     <= 1'b1;
			rx_sync_ff     <= 1'b1;
			tx_bit_pipe_ff <= 2'h3;
			tx_act_pipe_ff <= 2'h0;
			smp_pipe_ff    <= 2'h0;
		end else begin
			rx_meta_ff     <= i_lin_rx;
			rx_sync_ff     <= rx_meta_ff;
			tx_bit_pipe_ff <= {tx_bit_pipe_ff[0], i_tx_bit};
			tx_act_pipe_ff <= {tx_act_pipe_ff[0], i_tx_active};
			smp_pipe_ff    <= {smp_pipe_ff[0], i_bit_sample};
		end
	end

	// fault events
	assign ev[`LFB_F_SYNC] = q_take & is_sync & slave_ff
	                         & (q_byte.data != `LFB_SYNC_PATTERN);
	assign ev[`LFB_F_PAR]  = q_take & is_pid & slave_ff
	                         & ~parity_ok(q_byte.data);
	assign ev[`LFB_F_TIMEOUT_FAULT] = (resp_wait_ff & (resp_cnt_ff == RCW'(RESP_CYC - 1)))
	                       | (in_frame_ff & (frame_cnt_ff == FCW'(FRAME_CYC - 1)))
	                       | (q_take & is_data & first_data_ff & slave_ff
	                          & ~data_acknowledge_ff & ~stop_ff);
	assign ev[`LFB_F_CHK]  = q_take & is_csum
	                         & (q_byte.data != ~sum_ff);
	assign ev[`LFB_F_BIT]  = tx_act_pipe_ff[1] & smp_pipe_ff[1]
	                         & (rx_sync_ff != tx_bit_pipe_ff[1]);

	// sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			fault_ff <= `LFB_RST_FAULT;
			err_ff   <= 1'b0;
			int_ff   <= 1'b0;
		end else begin
			fault_ff <= (fault_ff & ~{`LFB_F_W{clr_err}}) | ev;
			err_ff   <= (err_ff & ~clr_err) | (|ev);
			int_ff   <= (int_ff & ~clr_int) | (|ev);
		end
	end

	assign o_fault_error       = err_ff;
	assign o_fault_irq_pending = int_ff;

endmodule

`default_nettype wire
